// ---- shared/xyb_map.vh ----
// Constants for the XY coordinate buffer: field positions, flag bits,
// reset values and timing counts.
// Assumes it is included by bare name from every design file that needs it.
`ifndef XYB_MAP_VH
`define XYB_MAP_VH

// =====================================================================
// Host word layout
// =====================================================================
`define XYB_WORD_W 36
`define XYB_COORD_W 10
`define XYB_X_LSB 0
`define XYB_Y_LSB 18
`define XYB_MSB_IDX 9

// =====================================================================
// Coordinate FIFO shape
// =====================================================================
`define XYB_FIFO_W 20
`define XYB_FIFO_DEPTH 16
`define XYB_FIFO_AW 4

// =====================================================================
// Control flag positions in the condition words
// =====================================================================
`define XYB_FLAG_W 4
`define XYB_FLAG_READY 0
`define XYB_FLAG_X_ONLY 1
`define XYB_FLAG_Y_ONLY 2
`define XYB_FLAG_BUSY 3

// =====================================================================
// Reset values
// =====================================================================
`define XYB_RST_READY 1'b1
`define XYB_RST_X_ONLY 1'b0
`define XYB_RST_Y_ONLY 1'b0
`define XYB_RST_BUSY 1'b0

// =====================================================================
// Timing
// =====================================================================
`define XYB_CLK_PERIOD_NS 8
`define XYB_SETTLE_NS 3000
`define XYB_SETTLE_CYC ((`XYB_SETTLE_NS + `XYB_CLK_PERIOD_NS - 1) / `XYB_CLK_PERIOD_NS)
`define XYB_CNT_W 9

`endif

// ---- verilog/xyb_fifo.v ----
// Synchronous FIFO for coordinate pairs with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module xyb_fifo #(
    parameter W = 20,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_in,              // System clock
    input wire rst_in,              // Async reset, active high
    input wire in_valid_in,         // Writer offers a word
    output wire in_ready_out,       // Space available
    input wire [W-1:0] in_data_in,  // Word to store
    output wire out_valid_out,      // Word available
    input wire out_ready_in,        // Reader takes the word
    output wire [W-1:0] out_data_out // Oldest word
);

    // =================================================================
    // Storage and pointers
    // =================================================================
    reg [W-1:0] mem [0:DEPTH-1];    // Word storage
    reg [AW:0] wr_ptr_ff;           // Write pointer with wrap bit
    reg [AW:0] rd_ptr_ff;           // Read pointer with wrap bit
    wire full;                      // Wrap bits differ, addresses match
    wire empty;                     // Pointers equal
    wire do_wr;                     // Accepted write
    wire do_rd;                     // Accepted read

    assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                  (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign in_ready_out = ~full;
    assign out_valid_out = ~empty;
    assign do_wr = in_valid_in & ~full;
    assign do_rd = out_ready_in & ~empty;
    assign out_data_out = mem[rd_ptr_ff[AW-1:0]];

    // =================================================================
    // Array write; no reset so it maps onto plain memory
    // =================================================================
    always @(posedge clk_in) begin
        if (do_wr) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data_in;
        end
    end

    // =================================================================
    // Pointer update
    // =================================================================
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_ff <= {(AW+1){1'b0}};
            rd_ptr_ff <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ---- verilog/xyb_coord_reg.v ----
// One ten-stage coordinate buffer: clear to zero, then set-only load.
// Assumes the sequencer never raises clear and set in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "xyb_map.vh"

module xyb_coord_reg (
    input wire clk_in,                       // System clock
    input wire rst_in,                       // Async reset, active high
    input wire clear_in,                     // Force all stages to zero
    input wire set_in,                       // OR the data into the stages
    input wire [`XYB_COORD_W-1:0] data_in,   // Bits from the host word
    output reg [`XYB_COORD_W-1:0] coord_out  // Held coordinate level
);

    // =================================================================
    // Stage update
    // =================================================================
    // Set only raises bits; stale ones would survive without a clear
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            coord_out <= {`XYB_COORD_W{1'b0}};
        end else if (clear_in) begin
            coord_out <= {`XYB_COORD_W{1'b0}};
        end else if (set_in) begin
            coord_out <= coord_out | data_in;
        end
    end

endmodule
`default_nettype wire

// ---- verilog/xyb_top.v ----
// Top of the XY coordinate buffer: host word path, control flags,
// sequencing logic and the coordinate levels to the point display.
// Assumes host command strobes come from logic on MCLK_IN; the display
// done pulse arrives from a pin and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "xyb_map.vh"

module xyb_top (
    input wire MCLK_IN,                          // 125 MHz system clock
    input wire RST_IN,                           // Async reset, active high
    input wire HOST_WORD_VALID_IN,               // Host word-out command
    input wire [`XYB_WORD_W-1:0] HOST_WORD_IN,   // Host data word
    output wire HOST_WORD_READY_OUT,             // FIFO can take a word
    input wire HOST_COND_OUT_IN,                 // Condition-out strobe
    input wire [`XYB_FLAG_W-1:0] HOST_COND_DATA_IN, // Flags to set
    input wire HOST_COND_IN_IN,                  // Condition-in strobe
    output reg [`XYB_FLAG_W-1:0] HOST_STATUS_OUT, // Sampled flags
    input wire DISP_DONE_IN,                     // Display done pulse, async
    output reg LOAD_DISPLAY_OUT,                 // Load display pulse
    output wire [`XYB_COORD_W-1:0] X_COORD_OUT,  // Horizontal level
    output wire [`XYB_COORD_W-1:0] Y_COORD_OUT   // Vertical level
);

    // =================================================================
    // Sequencer states
    // =================================================================
    localparam [2:0] ST_IDLE = 3'b000;   // Waiting for word and ready
    localparam [2:0] ST_CLEAR = 3'b001;  // Clear pulses issued
    localparam [2:0] ST_SET = 3'b010;    // Set pulses issued
    localparam [2:0] ST_SETTLE = 3'b011; // Levels settling at display
    localparam [2:0] ST_LOAD = 3'b100;   // Waiting for display idle

    localparam integer SETTLE_LAST_I = `XYB_SETTLE_CYC - 1;  // Full-width settle count
    localparam [`XYB_CNT_W-1:0] SETTLE_LAST = SETTLE_LAST_I[`XYB_CNT_W-1:0];

    // =================================================================
    // Declarations
    // =================================================================
    reg [2:0] state_ff;                  // Sequencer state
    reg [2:0] nxt_state;                 // Next sequencer state
    reg [`XYB_CNT_W-1:0] cnt_ff;         // Settle down-counter
    reg [`XYB_CNT_W-1:0] nxt_cnt;        // Next counter value
    reg [`XYB_FIFO_W-1:0] word_ff;       // Pair being loaded
    reg [`XYB_FIFO_W-1:0] nxt_word;      // Next held pair
    reg ready_ff;                        // Interface ready flag
    reg x_only_ff;                       // X-exclusive flag
    reg y_only_ff;                       // Y-exclusive flag
    reg busy_ff;                         // Display busy flag
    reg done_s1_ff;                      // Sync stage one
    reg done_s2_ff;                      // Sync stage two
    reg done_s3_ff;                      // Edge detect history
    reg take_word;                       // Pop FIFO this cycle
    reg clr_pulse;                       // Clear both buffers
    reg set_pulse;                       // Set both buffers
    reg ldp_pulse;                       // Load display this cycle
    wire done_pulse;                     // Display finished a point
    wire fifo_valid;                     // FIFO holds a pair
    wire [`XYB_FIFO_W-1:0] fifo_data;    // Oldest pair
    wire [`XYB_FIFO_W-1:0] host_pair;    // Pair cut from host word
    wire clr_x;                          // Gated X clear
    wire clr_y;                          // Gated Y clear
    wire set_x;                          // Gated X set
    wire set_y;                          // Gated Y set
    wire [`XYB_COORD_W-1:0] x_q;         // X stages, true sense
    wire [`XYB_COORD_W-1:0] y_q;         // Y stages, true sense

    // =================================================================
    // Host word path
    // =================================================================
    // Only the coordinate bits are kept, cutting the FIFO width from 36 to 20 bits
    assign host_pair = {
        HOST_WORD_IN[`XYB_Y_LSB +: `XYB_COORD_W],
        HOST_WORD_IN[`XYB_X_LSB +: `XYB_COORD_W]
    };

    // Sixteen queued pairs absorb host bursts; ready stalls the host
    xyb_fifo #(
        .W(`XYB_FIFO_W),
        .DEPTH(`XYB_FIFO_DEPTH),
        .AW(`XYB_FIFO_AW)
    ) u_fifo (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .in_valid_in(HOST_WORD_VALID_IN),
        .in_ready_out(HOST_WORD_READY_OUT),
        .in_data_in(host_pair),
        .out_valid_out(fifo_valid),
        .out_ready_in(take_word),
        .out_data_out(fifo_data)
    );

    // =================================================================
    // Display done synchroniser
    // =================================================================
    // Stage one feeds stage two only; edges are taken after that
    always @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            done_s1_ff <= 1'b0;
            done_s2_ff <= 1'b0;
            done_s3_ff <= 1'b0;
        end else begin
            done_s1_ff <= DISP_DONE_IN;
            done_s2_ff <= done_s1_ff;
            done_s3_ff <= done_s2_ff;
        end
    end

    assign done_pulse = done_s2_ff & ~done_s3_ff;

    // =================================================================
    // Sequencing logic
    // =================================================================
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_word = word_ff;
        take_word = 1'b0;
        clr_pulse = 1'b0;
        set_pulse = 1'b0;
        ldp_pulse = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                // A word is taken only while the interface is ready
                if (fifo_valid && ready_ff) begin
                    take_word = 1'b1;
                    nxt_word = fifo_data;
                    nxt_state = ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                // Clear first so no old bit survives the set
                clr_pulse = 1'b1;
                nxt_state = ST_SET;
            end
            ST_SET: begin
                set_pulse = 1'b1;
                nxt_cnt = SETTLE_LAST;
                nxt_state = ST_SETTLE;
            end
            ST_SETTLE: begin
                // Hold levels steady before the display reads them
                if (cnt_ff == {`XYB_CNT_W{1'b0}}) begin
                    nxt_state = ST_LOAD;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            ST_LOAD: begin
                // The display keeps plotting the old point meanwhile
                if (!busy_ff) begin
                    ldp_pulse = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_ff <= ST_IDLE;
            cnt_ff <= {`XYB_CNT_W{1'b0}};
            word_ff <= {`XYB_FIFO_W{1'b0}};
            LOAD_DISPLAY_OUT <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            word_ff <= nxt_word;
            LOAD_DISPLAY_OUT <= ldp_pulse;
        end
    end

    // =================================================================
    // Pulse gating by the exclusive flags
    // =================================================================
    // Y-only freezes X, X-only freezes Y
    assign clr_x = clr_pulse & ~y_only_ff;
    assign set_x = set_pulse & ~y_only_ff;
    assign clr_y = clr_pulse & ~x_only_ff;
    assign set_y = set_pulse & ~x_only_ff;

    // =================================================================
    // Coordinate buffers
    // =================================================================
    // X buffer, from the right half of the host word
    xyb_coord_reg u_x_buf (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .clear_in(clr_x),
        .set_in(set_x),
        .data_in(word_ff[`XYB_COORD_W-1:0]),
        .coord_out(x_q)
    );

    // Y buffer, from the left half of the host word
    xyb_coord_reg u_y_buf (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .clear_in(clr_y),
        .set_in(set_y),
        .data_in(word_ff[`XYB_FIFO_W-1:`XYB_COORD_W]),
        .coord_out(y_q)
    );

    // =================================================================
    // Display levels
    // =================================================================
    // The display reads its top stage in the opposite sense
    assign X_COORD_OUT = {~x_q[`XYB_MSB_IDX], x_q[`XYB_MSB_IDX-1:0]};
    assign Y_COORD_OUT = {~y_q[`XYB_MSB_IDX], y_q[`XYB_MSB_IDX-1:0]};

    // =================================================================
    // Control flags
    // =================================================================
    // Condition-out clears every flag and sets the settable ones.
    // Hardware sets win over a clear in the same cycle so no event is lost.
    always @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ready_ff <= `XYB_RST_READY;
            x_only_ff <= `XYB_RST_X_ONLY;
            y_only_ff <= `XYB_RST_Y_ONLY;
            busy_ff <= `XYB_RST_BUSY;
        end else begin
            // Ready: set by load pulse, cleared by word take, loaded from the flag word by cond-out
            if (ldp_pulse) begin
                ready_ff <= 1'b1;
            end else if (take_word) begin
                ready_ff <= 1'b0;
            end else if (HOST_COND_OUT_IN) begin
                ready_ff <= HOST_COND_DATA_IN[`XYB_FLAG_READY];
            end
            // Exclusive flags change only by host command
            if (HOST_COND_OUT_IN) begin
                x_only_ff <= HOST_COND_DATA_IN[`XYB_FLAG_X_ONLY];
                y_only_ff <= HOST_COND_DATA_IN[`XYB_FLAG_Y_ONLY];
            end
            // Busy cannot be set by the host, only cleared
            if (ldp_pulse) begin
                busy_ff <= 1'b1;
            end else if (done_pulse || HOST_COND_OUT_IN) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // =================================================================
    // Condition-in sampling
    // =================================================================
    // Status holds its value until the next condition-in strobe
    always @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            HOST_STATUS_OUT <= {`XYB_FLAG_W{1'b0}};
        end else if (HOST_COND_IN_IN) begin
            HOST_STATUS_OUT[`XYB_FLAG_READY] <= ready_ff;
            HOST_STATUS_OUT[`XYB_FLAG_X_ONLY] <= x_only_ff;
            HOST_STATUS_OUT[`XYB_FLAG_Y_ONLY] <= y_only_ff;
            HOST_STATUS_OUT[`XYB_FLAG_BUSY] <= busy_ff;
        end
    end

endmodule
`default_nettype wire

// ---- verification/xyb_props.sv ----
// Checker for the XY coordinate buffer: timing of levels, load pulse, status.
// Assumes it is bound to xyb_top and that xyb_map.vh is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "xyb_map.vh"

module xyb_props (
    input wire logic MCLK_IN, // System clock
    input wire logic RST_IN, // Async reset, active high
    input wire logic HOST_WORD_VALID_IN, // Host offers a word
    input wire logic HOST_WORD_READY_OUT, // Space for a word
    input wire logic HOST_COND_IN_IN, // Status sample strobe
    input wire logic [`XYB_FLAG_W-1:0] HOST_STATUS_OUT, // Sampled flags
    input wire logic LOAD_DISPLAY_OUT, // Load display pulse
    input wire logic [`XYB_COORD_W-1:0] X_COORD_OUT, // Horizontal level
    input wire logic [`XYB_COORD_W-1:0] Y_COORD_OUT // Vertical level
);
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (RST_IN);

    // ==================================================================
    // Cycles since the levels last moved
    // ==================================================================
    // Saturates so a long idle spell never wraps back below the settle figure
    logic [9:0] stab_ff;
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            stab_ff <= 10'h000;
        end else if ($changed(X_COORD_OUT) || $changed(Y_COORD_OUT)) begin
            stab_ff <= 10'h000;
        end else if (stab_ff != 10'h3FF) begin
            stab_ff <= stab_ff + 10'h001;
        end
    end

    // ==================================================================
    // Properties
    // ==================================================================
    a_settle_before_load: assert property (LOAD_DISPLAY_OUT |-> stab_ff >= 10'h175)
        else $error("Load pulse before levels settled");
    a_load_pulse_gap: assert property (LOAD_DISPLAY_OUT |=> !LOAD_DISPLAY_OUT [*8])
        else $error("Load pulse too long or repeated");
    a_levels_at_load: assert property (LOAD_DISPLAY_OUT |=>
        $stable(X_COORD_OUT) && $stable(Y_COORD_OUT))
        else $error("Levels moved during transfer");
    a_reset_levels: assert property ($fell(RST_IN) |-> X_COORD_OUT == 10'h200
        && Y_COORD_OUT == 10'h200 && HOST_WORD_READY_OUT && !LOAD_DISPLAY_OUT)
        else $error("Wrong levels after reset");
    a_status_holds: assert property (!HOST_COND_IN_IN |=> $stable(HOST_STATUS_OUT))
        else $error("Status moved without a sample strobe");
    a_ready_falls_take: assert property ($fell(HOST_WORD_READY_OUT) |->
        $past(HOST_WORD_VALID_IN))
        else $error("Word space lost without a word taken");
    a_x_clear_first: assert property ($changed(X_COORD_OUT) && X_COORD_OUT != 10'h200
        |-> $past(X_COORD_OUT) == 10'h200)
        else $error("X loaded without a clear before it");
    a_y_clear_first: assert property ($changed(Y_COORD_OUT) && Y_COORD_OUT != 10'h200
        |-> $past(Y_COORD_OUT) == 10'h200)
        else $error("Y loaded without a clear before it");

    c_load: cover property (LOAD_DISPLAY_OUT);
    c_refused: cover property (HOST_WORD_VALID_IN && !HOST_WORD_READY_OUT);
    c_status: cover property (HOST_COND_IN_IN);
endmodule

bind xyb_top xyb_props u_props (
    .MCLK_IN(MCLK_IN),
    .RST_IN(RST_IN),
    .HOST_WORD_VALID_IN(HOST_WORD_VALID_IN),
    .HOST_WORD_READY_OUT(HOST_WORD_READY_OUT),
    .HOST_COND_IN_IN(HOST_COND_IN_IN),
    .HOST_STATUS_OUT(HOST_STATUS_OUT),
    .LOAD_DISPLAY_OUT(LOAD_DISPLAY_OUT),
    .X_COORD_OUT(X_COORD_OUT),
    .Y_COORD_OUT(Y_COORD_OUT)
);
`default_nettype wire

// ---- verification/xyb_disp_model.sv ----
// Point display model: takes both levels on the load pulse, plots, signals done.
// Assumes the load pulse is one clock wide and dly_in is at least 3.
`timescale 1ns/1ps
`default_nettype none

module xyb_disp_model (
    input wire logic clk_in, // System clock
    input wire logic rst_in, // Async reset
    input wire logic load_in, // Load display pulse
    input wire logic [9:0] x_in, // Horizontal level
    input wire logic [9:0] y_in, // Vertical level
    input wire logic [15:0] dly_in, // Plot time in cycles
    output logic done_out, // Done pulse, two cycles so the sync sees it
    output logic [9:0] x_seen_out, // Horizontal buffer, true sense
    output logic [9:0] y_seen_out, // Vertical buffer, true sense
    output logic [7:0] loads_out // Transfers seen
);
    logic [15:0] plot_ff; // Cycles left in the current plot

    // ==================================================================
    // Transfer and plot timer
    // ==================================================================
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            plot_ff <= 16'h0000;
            done_out <= 1'b0;
            x_seen_out <= 10'h000;
            y_seen_out <= 10'h000;
            loads_out <= 8'h00;
        end else begin
            done_out <= (plot_ff == 16'h0002) || (plot_ff == 16'h0001);
            if (load_in) begin
                // Both buffers at once; top stage has the opposite sense
                x_seen_out <= x_in ^ 10'h200;
                y_seen_out <= y_in ^ 10'h200;
                loads_out <= loads_out + 8'h01;
                plot_ff <= dly_in;
            end else if (plot_ff != 16'h0000) begin
                plot_ff <= plot_ff - 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the XY coordinate buffer with a display model.
// Assumes the design files, checker and display model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk, rst, w_valid, c_out, c_in; // Clock, reset, strobes
    logic [35:0] w_data; // Host word
    logic [3:0] c_data; // Flags for condition out
    logic [15:0] dly; // Display plot time
    wire logic w_ready, load, done;
    wire logic [3:0] status;
    wire logic [9:0] x_lvl, y_lvl, xs, ys;
    wire logic [7:0] loads;
    int miscompares = 0;
    int samples_checked = 0;
    logic [3:0] s;

    xyb_top u_dut (.MCLK_IN(clk), .RST_IN(rst), .HOST_WORD_VALID_IN(w_valid),
        .HOST_WORD_IN(w_data), .HOST_WORD_READY_OUT(w_ready), .HOST_COND_OUT_IN(c_out),
        .HOST_COND_DATA_IN(c_data), .HOST_COND_IN_IN(c_in), .HOST_STATUS_OUT(status),
        .DISP_DONE_IN(done), .LOAD_DISPLAY_OUT(load), .X_COORD_OUT(x_lvl), .Y_COORD_OUT(y_lvl));
    xyb_disp_model u_disp (.clk_in(clk), .rst_in(rst), .load_in(load), .x_in(x_lvl),
        .y_in(y_lvl), .dly_in(dly), .done_out(done), .x_seen_out(xs), .y_seen_out(ys),
        .loads_out(loads));

    // ==================================================================
    // Shared tasks
    // ==================================================================
    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Junk in the unused bits must never reach the levels
    task automatic send(input logic [9:0] x, input logic [9:0] y);
        int n;
        n = 0;
        @(negedge clk);
        w_data = {8'hFF, y, 8'hFF, x};
        w_valid = 1'b1;
        // Ready moves only at rising edges, so its low-phase value is the one taken
        while (w_ready !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        chk("word space", w_ready, 1'b1);
        @(negedge clk);
        w_valid = 1'b0;
    endtask
    task automatic cond(input logic [3:0] f);
        @(negedge clk);
        c_data = f;
        c_out = 1'b1;
        @(negedge clk);
        c_out = 1'b0;
    endtask
    task automatic rd(output logic [3:0] f);
        @(negedge clk);
        c_in = 1'b1;
        @(negedge clk);
        c_in = 1'b0;
        f = status;
    endtask
    task automatic wait_loads(input logic [7:0] n);
        int i;
        i = 0;
        while (loads !== n && i < 3000) begin
            @(negedge clk);
            i++;
        end
        chk("load count", loads, n);
    endtask

    // ==================================================================
    // Scenarios
    // ==================================================================
    task automatic t_reset();
        chk("x reset", x_lvl, 10'h200);
        chk("y reset", y_lvl, 10'h200);
        chk("space", w_ready, 1'b1);
        rd(s);
        chk("flags reset", s, 4'h1);
    endtask
    task automatic t_single();
        send(10'h2A5, 10'h15A);
        wait_loads(8'h01);
        chk("x level", x_lvl, 10'h0A5);
        chk("x seen", xs, 10'h2A5);
        chk("y seen", ys, 10'h15A);
        rd(s);
        chk("ready busy", s, 4'h9);
        cyc(60);
        rd(s);
        chk("after done", s, 4'h1);
    endtask
    // Second word lands while the display still plots the first
    task automatic t_double();
        dly = 16'h0258;
        send(10'h3FF, 10'h3FF);
        send(10'h001, 10'h200);
        wait_loads(8'h02);
        chk("first x", xs, 10'h3FF);
        cyc(20);
        chk("next x held", x_lvl, 10'h201);
        chk("next y held", y_lvl, 10'h000);
        chk("no early load", loads, 8'h02);
        wait_loads(8'h03);
        chk("x no residue", xs, 10'h001);
        chk("y no residue", ys, 10'h200);
        dly = 16'h0028;
    endtask
    // The busy bit in the flag word must be ignored by condition-out
    task automatic t_exclusive();
        cond(4'b1101);
        rd(s);
        chk("y only set", s, 4'h5);
        send(10'h111, 10'h222);
        wait_loads(8'h04);
        chk("x kept", xs, 10'h001);
        chk("y new", ys, 10'h222);
        cond(4'b0011);
        send(10'h333, 10'h044);
        wait_loads(8'h05);
        chk("x new", xs, 10'h333);
        chk("y kept", ys, 10'h222);
    endtask
    // Fill the buffer with the ready flag cleared, then drain in order
    task automatic t_fill();
        cond(4'b0000);
        rd(s);
        chk("flags cleared", s, 4'h0);
        for (int i = 0; i < 16; i++) begin
            send(i[9:0], 10'h3FF - i[9:0]);
        end
        chk("full refuses", w_ready, 1'b0);
        fork
            send(10'h3C0, 10'h03C);
            begin
                cyc(5);
                chk("held off", loads, 8'h05);
                cond(4'b0001);
            end
        join
        for (int i = 0; i < 16; i++) begin
            wait_loads(8'h06 + i[7:0]);
            chk("drain x", xs, i[9:0]);
            chk("drain y", ys, 10'h3FF - i[9:0]);
        end
        wait_loads(8'h16);
        chk("last x", xs, 10'h3C0);
    endtask

    // ==================================================================
    // Clock, sequence, watchdog, verdict
    // ==================================================================
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        w_valid = 1'b0;
        w_data = 36'h0;
        c_out = 1'b0;
        c_in = 1'b0;
        c_data = 4'h0;
        dly = 16'h0028;
        cyc(10);
        rst = 1'b0;
        t_reset();
        t_single();
        t_double();
        t_exclusive();
        t_fill();
        conclude();
    end
    // Whole run needs about 9000 cycles; allow well over twice that
    initial begin
        #320000;
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
